//--- core/eicl_loader.sv
// Summary of operation
// - revision field: bits 1:0 read zero, revision code in bits 4:2
// - asic type code sits in bits 7:5 of read-only silicon revision
// - silicon revision bits 6:2 mirrored into five-bit diagnostic revision field
// - eeprom word 18h loaded after reset as read-only board subsystem identifier
// - eeprom word 17h loaded after reset as read-only board subsystem vendor
// - fixed read-only 16-bit maker identification, unchangeable by software
// - eeprom word 03 loaded as configuration product identifier
// - product identifier low nibble is variant, upper three nibbles product number
// - with 4K eeprom word ff checksums words 40 to fe
// - with 16K eeprom word 3ff checksums words 40 to 3fe
// - legacy maker code word 07 is never used nor copied anywhere
// - primary node address words 00 to 02 never program node address
// - alternate node address words copied into node address register after reset
// - bus parameter word loaded from eeprom, default 1540h until then
`timescale 1ns/1ps
module eicl_loader
   import eicl_pkg::*;
#(
   parameter logic [15:0] MAKER_IDENT = 16'h5a5a, // arbitrary value
   parameter logic [2:0] ASIC_TYPE = 3'h2, // arbitrary value
   parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
)
(
   input wire logic clk,
   input wire logic rst_b,
   output logic ee_req,
   output logic [9:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   input wire logic ee_large,
   output logic [9:0] ee_csum_addr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   output logic cfg_rd_valid,
   output logic cfg_retry,
   output logic [31:0] cfg_rd_data,
   output logic [7:0] silicon_rev_reg,
   output logic [4:0] diag_rev_mirror,
   output logic [15:0] maker_ident_reg,
   output logic [15:0] product_ident,
   output logic [11:0] product_number,
   output logic [3:0] product_variant,
   output logic [15:0] board_sub_vendor,
   output logic [15:0] board_sub_ident,
   output logic [47:0] node_addr_reg,
   output logic [15:0] bus_param_word,
   output logic pulsed_pme,
   output logic map_lower_meg,
   output logic no_mem_base,
   output logic [3:0] min_gnt,
   output logic [5:0] max_lat,
   output logic loaded
);
   eicl_word_if wo();

   logic [15:0] product_q;
   logic [15:0] sub_vendor_q;
   logic [15:0] sub_ident_q;
   logic [15:0] node0_q;
   logic [15:0] node1_q;
   logic [15:0] node2_q;
   logic [15:0] bus_param_q;
   logic loaded_q;
   logic rd_valid_q;
   logic [31:0] rd_data_q;

   eicl_fetch u_fetch (
      .clk(clk),
      .rst_b(rst_b),
      .ee_req(ee_req),
      .ee_addr(ee_addr),
      .ee_ack(ee_ack),
      .ee_data(ee_data),
      .wo(wo)
   );

   // write strobes per fetched word; ignored once loading is over
   wire logic wr_ok = wo.wr && !loaded_q;
   wire logic wr_product = wr_ok && (wo.idx == EICL_IX_PRODUCT);
   wire logic wr_bus_param = wr_ok && (wo.idx == EICL_IX_BUS_PARAM);
   wire logic wr_node0 = wr_ok && (wo.idx == EICL_IX_NODE0);
   wire logic wr_node1 = wr_ok && (wo.idx == EICL_IX_NODE1);
   wire logic wr_node2 = wr_ok && (wo.idx == EICL_IX_NODE2);
   wire logic wr_sub_vendor = wr_ok && (wo.idx == EICL_IX_SUB_VENDOR);
   wire logic wr_sub_ident = wr_ok && (wo.idx == EICL_IX_SUB_IDENT);

   // fixed identity: revision byte built from constants, no write path exists
   wire logic [7:0] rev_byte = {ASIC_TYPE, REV_CODE, EICL_REV_ZERO};

   // configuration read decode
   wire logic hit_ident = (cfg_addr == EICL_CFG_IDENT);
   wire logic hit_rev = (cfg_addr == EICL_CFG_REV);
   wire logic hit_subsys = (cfg_addr == EICL_CFG_SUBSYS);
   wire logic [31:0] rd_ident = {product_q, MAKER_IDENT};
   wire logic [31:0] rd_rev = {24'h000000, rev_byte};
   wire logic [31:0] rd_subsys = {sub_ident_q, sub_vendor_q};
   wire logic [31:0] rd_mux = hit_ident ? rd_ident :
                              hit_rev ? rd_rev :
                              hit_subsys ? rd_subsys : 32'h00000000;
   wire logic rd_take = cfg_rd && loaded_q;

   // each identity register keeps its value unless its own fetch lands
   wire logic [15:0] product_d = wr_product ? wo.data : product_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         product_q <= 16'h0000;
      end else begin
         product_q <= product_d;
      end
   end

   wire logic [15:0] sub_vendor_d = wr_sub_vendor ? wo.data : sub_vendor_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sub_vendor_q <= 16'h0000;
      end else begin
         sub_vendor_q <= sub_vendor_d;
      end
   end

   wire logic [15:0] sub_ident_d = wr_sub_ident ? wo.data : sub_ident_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sub_ident_q <= 16'h0000;
      end else begin
         sub_ident_q <= sub_ident_d;
      end
   end

   // node address comes from the alternate words only, low word first
   wire logic [15:0] node0_d = wr_node0 ? wo.data : node0_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         node0_q <= 16'h0000;
      end else begin
         node0_q <= node0_d;
      end
   end

   wire logic [15:0] node1_d = wr_node1 ? wo.data : node1_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         node1_q <= 16'h0000;
      end else begin
         node1_q <= node1_d;
      end
   end

   wire logic [15:0] node2_d = wr_node2 ? wo.data : node2_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         node2_q <= 16'h0000;
      end else begin
         node2_q <= node2_d;
      end
   end

   // bus parameters run on the default until the eeprom word arrives
   wire logic [15:0] bus_param_d = wr_bus_param ? wo.data : bus_param_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bus_param_q <= EICL_BUS_PARAM_RST;
      end else begin
         bus_param_q <= bus_param_d;
      end
   end

   // loaded never falls again before reset, which freezes every identity register
   wire logic loaded_d = loaded_q || wo.done;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         loaded_q <= 1'b0;
      end else begin
         loaded_q <= loaded_d;
      end
   end

   wire logic rd_valid_d = rd_take;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_valid_d;
      end
   end

   wire logic [31:0] rd_data_d = rd_take ? rd_mux : rd_data_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data_q <= 32'h00000000;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // checksum word location depends on the fitted part size
   assign ee_csum_addr = ee_large ? EICL_EE_CSUM_16K : EICL_EE_CSUM_4K;

   assign cfg_retry = cfg_rd && !loaded_q;
   assign cfg_rd_valid = rd_valid_q;
   assign cfg_rd_data = rd_data_q;

   assign silicon_rev_reg = rev_byte;
   assign diag_rev_mirror = rev_byte[EICL_DIAG_MSB:EICL_DIAG_LSB];
   assign maker_ident_reg = MAKER_IDENT;
   assign product_ident = product_q;
   assign product_variant = product_q[EICL_PROD_VARIANT_MSB:0];
   assign product_number = product_q[15:EICL_PROD_NUMBER_LSB];
   assign board_sub_vendor = sub_vendor_q;
   assign board_sub_ident = sub_ident_q;
   assign node_addr_reg = {node2_q, node1_q, node0_q};
   assign bus_param_word = bus_param_q;
   assign pulsed_pme = bus_param_q[EICL_BP_PULSED_PME];
   assign map_lower_meg = bus_param_q[EICL_BP_LOWER_MEG];
   assign no_mem_base = bus_param_q[EICL_BP_NO_MEMBASE];
   assign min_gnt = bus_param_q[EICL_BP_MIN_GNT_MSB:EICL_BP_MIN_GNT_LSB];
   assign max_lat = bus_param_q[EICL_BP_MAX_LAT_MSB:EICL_BP_MAX_LAT_LSB];
   assign loaded = loaded_q;
endmodule

//--- core/eicl_pkg.sv
package eicl_pkg;
   // eeprom word map
   localparam logic [9:0] EICL_EE_NODE_PRI0 = 10'h000;
   localparam logic [9:0] EICL_EE_NODE_PRI2 = 10'h002;
   localparam logic [9:0] EICL_EE_PRODUCT = 10'h003;
   localparam logic [9:0] EICL_EE_MFG_DATE = 10'h004;
   localparam logic [9:0] EICL_EE_LEGACY_MAKER = 10'h007;
   localparam logic [9:0] EICL_EE_BUS_PARAM = 10'h008;
   localparam logic [9:0] EICL_EE_ROM_INFO = 10'h009;
   localparam logic [9:0] EICL_EE_NODE_ALT0 = 10'h00a;
   localparam logic [9:0] EICL_EE_NODE_ALT1 = 10'h00b;
   localparam logic [9:0] EICL_EE_NODE_ALT2 = 10'h00c;
   localparam logic [9:0] EICL_EE_SUB_VENDOR = 10'h017;
   localparam logic [9:0] EICL_EE_SUB_IDENT = 10'h018;
   localparam logic [9:0] EICL_EE_IP_LO = 10'h030;
   localparam logic [9:0] EICL_EE_IP_HI = 10'h031;
   localparam logic [9:0] EICL_EE_FLEX_FIRST = 10'h040;
   localparam logic [9:0] EICL_EE_CSUM_4K = 10'h0ff;
   localparam logic [9:0] EICL_EE_CSUM_16K = 10'h3ff;

   // fetch order; index into this table travels with each fetched word
   localparam int EICL_NFETCH = 7;
   localparam logic [2:0] EICL_IX_PRODUCT = 3'h0;
   localparam logic [2:0] EICL_IX_BUS_PARAM = 3'h1;
   localparam logic [2:0] EICL_IX_NODE0 = 3'h2;
   localparam logic [2:0] EICL_IX_NODE1 = 3'h3;
   localparam logic [2:0] EICL_IX_NODE2 = 3'h4;
   localparam logic [2:0] EICL_IX_SUB_VENDOR = 3'h5;
   localparam logic [2:0] EICL_IX_SUB_IDENT = 3'h6;
   localparam logic [2:0] EICL_IX_LAST = 3'h6;

   // configuration space byte offsets (dword aligned)
   localparam logic [7:0] EICL_CFG_IDENT = 8'h00;
   localparam logic [7:0] EICL_CFG_REV = 8'h08;
   localparam logic [7:0] EICL_CFG_SUBSYS = 8'h2c;

   // silicon revision layout
   localparam int EICL_REV_ZERO_LSB = 0;
   localparam int EICL_REV_CODE_LSB = 2;
   localparam int EICL_REV_TYPE_LSB = 5;
   localparam logic [1:0] EICL_REV_ZERO = 2'h0;
   localparam int EICL_DIAG_LSB = 2;
   localparam int EICL_DIAG_MSB = 6;

   // product identifier layout
   localparam int EICL_PROD_VARIANT_MSB = 3;
   localparam int EICL_PROD_NUMBER_LSB = 4;

   // bus parameter word layout and default
   localparam logic [15:0] EICL_BUS_PARAM_RST = 16'h1540;
   localparam int EICL_BP_PULSED_PME = 0;
   localparam int EICL_BP_LOWER_MEG = 1;
   localparam int EICL_BP_NO_MEMBASE = 2;
   localparam int EICL_BP_MIN_GNT_LSB = 6;
   localparam int EICL_BP_MIN_GNT_MSB = 9;
   localparam int EICL_BP_MAX_LAT_LSB = 10;
   localparam int EICL_BP_MAX_LAT_MSB = 15;

   // fetcher states
   typedef enum logic [2:0] {
      EICL_FS_START = 3'b001,
      EICL_FS_WAIT = 3'b010,
      EICL_FS_DONE = 3'b100
   } eicl_fstate_t;

   function automatic logic [9:0] eicl_fetch_addr(input logic [2:0] ix);
      logic [9:0] a;
      a = EICL_EE_PRODUCT;
      case (ix)
         EICL_IX_PRODUCT: a = EICL_EE_PRODUCT;
         EICL_IX_BUS_PARAM: a = EICL_EE_BUS_PARAM;
         EICL_IX_NODE0: a = EICL_EE_NODE_ALT0;
         EICL_IX_NODE1: a = EICL_EE_NODE_ALT1;
         EICL_IX_NODE2: a = EICL_EE_NODE_ALT2;
         EICL_IX_SUB_VENDOR: a = EICL_EE_SUB_VENDOR;
         EICL_IX_SUB_IDENT: a = EICL_EE_SUB_IDENT;
         default: a = EICL_EE_PRODUCT;
      endcase
      return a;
   endfunction
endpackage

//--- core/eicl_word_if.sv
`timescale 1ns/1ps
interface eicl_word_if;
   logic wr;
   logic [2:0] idx;
   logic [15:0] data;
   logic done;
   modport fetcher(output wr, output idx, output data, output done);
   modport sink(input wr, input idx, input data, input done);
endinterface

//--- core/eicl_fetch.sv
`timescale 1ns/1ps
// walks the fetch table once after reset, one eeprom word at a time
module eicl_fetch
   import eicl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   output logic ee_req,
   output logic [9:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   eicl_word_if.fetcher wo
);
   eicl_fstate_t state_q, state_d;
   logic [2:0] ix_q, ix_d;
   logic wr_q;
   logic [2:0] wr_ix_q;
   logic [15:0] wr_data_q;
   wire logic take = (state_q == EICL_FS_WAIT) && ee_ack;
   wire logic last = (ix_q == EICL_IX_LAST);

   always_comb begin
      state_d = state_q;
      ix_d = ix_q;
      case (state_q)
         EICL_FS_START: state_d = EICL_FS_WAIT;
         EICL_FS_WAIT: begin
            if (take) begin
               if (last) begin
                  state_d = EICL_FS_DONE;
               end else begin
                  ix_d = ix_q + 3'h1;
               end
            end
         end
         EICL_FS_DONE: state_d = EICL_FS_DONE;
         default: state_d = EICL_FS_START;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= EICL_FS_START;
         ix_q <= 3'h0;
         wr_q <= 1'b0;
         wr_ix_q <= 3'h0;
         wr_data_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         ix_q <= ix_d;
         wr_q <= take;
         wr_ix_q <= ix_q;
         wr_data_q <= ee_data;
      end
   end

   // only listed words are fetched; primary node words and legacy maker code never are
   assign ee_req = (state_q == EICL_FS_WAIT);
   assign ee_addr = eicl_fetch_addr(ix_q);
   assign wo.wr = wr_q;
   assign wo.idx = wr_ix_q;
   assign wo.data = wr_data_q;
   assign wo.done = (state_q == EICL_FS_DONE) && !wr_q;
endmodule

//--- testbench/eicl_loader_sva.sv
`timescale 1ns/1ps
module eicl_loader_sva
   import eicl_pkg::*;
#(
   parameter logic [15:0] MAKER_IDENT = 16'h5a5a, // arbitrary value
   parameter logic [2:0] ASIC_TYPE = 3'h2, // arbitrary value
   parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ee_req,
   input wire logic [9:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_data,
   input wire logic ee_large,
   input wire logic [9:0] ee_csum_addr,
   input wire logic cfg_rd,
   input wire logic cfg_rd_valid,
   input wire logic cfg_retry,
   input wire logic [7:0] silicon_rev_reg,
   input wire logic [4:0] diag_rev_mirror,
   input wire logic [15:0] maker_ident_reg,
   input wire logic [15:0] product_ident,
   input wire logic [11:0] product_number,
   input wire logic [3:0] product_variant,
   input wire logic [15:0] board_sub_vendor,
   input wire logic [15:0] board_sub_ident,
   input wire logic [47:0] node_addr_reg,
   input wire logic [15:0] bus_param_word,
   input wire logic loaded
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_took(a);
      ee_req && ee_ack && ee_addr == a;
   endsequence
   // the word is registered once in the fetcher, then once in its target
   property p_load(a, v);
      s_took(a) |-> ##2 v == $past(ee_data, 2);
   endproperty
   a_rev_layout: assert property (
      silicon_rev_reg == {ASIC_TYPE, REV_CODE, 2'h0}) else $error("revision layout wrong");
   a_diag_mirror: assert property (
      diag_rev_mirror == silicon_rev_reg[6:2]) else $error("diagnostic mirror wrong");
   a_maker_fixed: assert property (
      maker_ident_reg == MAKER_IDENT) else $error("maker ident changed");
   a_product_split: assert property (
      {product_number, product_variant} == product_ident) else $error("product split wrong");
   a_product_load: assert property (
      p_load(EICL_EE_PRODUCT, product_ident)) else $error("product not loaded");
   a_sub_ident: assert property (
      p_load(EICL_EE_SUB_IDENT, board_sub_ident)) else $error("sub ident not loaded");
   a_sub_vendor: assert property (
      p_load(EICL_EE_SUB_VENDOR, board_sub_vendor)) else $error("sub vendor not loaded");
   a_node_load: assert property (
      p_load(EICL_EE_NODE_ALT0, node_addr_reg[15:0])) else $error("node word not loaded");
   a_node_high: assert property (
      p_load(EICL_EE_NODE_ALT2, node_addr_reg[47:32])) else $error("node high not loaded");
   a_param_load: assert property (
      p_load(EICL_EE_BUS_PARAM, bus_param_word)) else $error("bus param not loaded");
   a_param_default: assert property (disable iff (1'b0)
      !rst_b |=> bus_param_word == EICL_BUS_PARAM_RST) else $error("bus param default wrong");
   a_skip_words: assert property (
      ee_req |-> ee_addr > EICL_EE_NODE_PRI2 && ee_addr != EICL_EE_LEGACY_MAKER)
      else $error("forbidden word fetched");
   a_csum_addr: assert property (
      ee_csum_addr == (ee_large ? EICL_EE_CSUM_16K : EICL_EE_CSUM_4K))
      else $error("checksum word address wrong");
   a_read_retry: assert property (
      cfg_rd && !loaded |-> cfg_retry ##1 !cfg_rd_valid) else $error("early read answered");
   a_read_answer: assert property (
      cfg_rd && loaded |=> cfg_rd_valid) else $error("read not answered");
   a_held_stable: assert property (
      loaded |=> loaded && $stable(product_ident) && $stable(node_addr_reg))
      else $error("loaded values moved");
endmodule
bind eicl_loader eicl_loader_sva #(
   .MAKER_IDENT(MAKER_IDENT),
   .ASIC_TYPE(ASIC_TYPE),
   .REV_CODE(REV_CODE)
) i_eicl_loader_sva (
   .clk(clk),
   .rst_b(rst_b),
   .ee_req(ee_req),
   .ee_addr(ee_addr),
   .ee_ack(ee_ack),
   .ee_data(ee_data),
   .ee_large(ee_large),
   .ee_csum_addr(ee_csum_addr),
   .cfg_rd(cfg_rd),
   .cfg_rd_valid(cfg_rd_valid),
   .cfg_retry(cfg_retry),
   .silicon_rev_reg(silicon_rev_reg),
   .diag_rev_mirror(diag_rev_mirror),
   .maker_ident_reg(maker_ident_reg),
   .product_ident(product_ident),
   .product_number(product_number),
   .product_variant(product_variant),
   .board_sub_vendor(board_sub_vendor),
   .board_sub_ident(board_sub_ident),
   .node_addr_reg(node_addr_reg),
   .bus_param_word(bus_param_word),
   .loaded(loaded)
);

//--- testbench/eicl_ee_model.sv
`timescale 1ns/1ps
module eicl_ee_model
   import eicl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ee_req,
   input wire logic [9:0] ee_addr,
   input wire logic [3:0] dly,
   output logic ee_ack,
   output logic [15:0] ee_data
);
   logic [3:0] cnt_q;
   logic [15:0] mem [1024];
   logic [15:0] csum;
   int i;

   // plain words carry their own address so a misrouted fetch shows up
   initial begin
      for (i = 0; i < 1024; i++) begin
         mem[i] = {i[9:0], 6'h25};
      end
      mem[EICL_EE_MFG_DATE] = {7'h63, 4'hc, 5'h1f};
      mem[EICL_EE_ROM_INFO] = {2'h0, 2'h1, 1'h1, 11'h000};
      mem[EICL_EE_IP_LO] = 16'h0a01;
      mem[EICL_EE_IP_HI] = 16'hc0a8;
      // checksum form is ours: xor of the covered words; both kept, part size unknown here
      csum = 16'h0000;
      for (i = EICL_EE_FLEX_FIRST; i < EICL_EE_CSUM_4K; i++) begin
         csum = csum ^ mem[i];
      end
      mem[EICL_EE_CSUM_4K] = csum;
      csum = 16'h0000;
      for (i = EICL_EE_FLEX_FIRST; i < EICL_EE_CSUM_16K; i++) begin
         csum = csum ^ mem[i];
      end
      mem[EICL_EE_CSUM_16K] = csum;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ee_ack <= 1'b0;
         cnt_q <= 4'h0;
         ee_data <= 16'h0000;
      end else if (ee_req && !ee_ack && cnt_q == dly) begin
         ee_ack <= 1'b1;
         cnt_q <= 4'h0;
         ee_data <= mem[ee_addr];
      end else begin
         ee_ack <= 1'b0;
         // stale word inverted every cycle outside the valid cycle
         ee_data <= ~ee_data;
         cnt_q <= (ee_req && !ee_ack) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

//--- testbench/test_eeprom_ident_config_loader.sv
`timescale 1ns/1ps
module test_eeprom_ident_config_loader;
   import eicl_pkg::*;
   localparam logic [7:0] REV = {3'h5, 3'h6, 2'h0};
   logic clk = 1'b0, rst_b = 1'b0, ee_large = 1'b0, cfg_rd = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] dly = 4'h0;
   logic ee_req, ee_ack, cfg_rd_valid, cfg_retry, loaded, pulsed_pme, map_lower_meg;
   logic no_mem_base;
   logic [9:0] ee_addr, ee_csum_addr;
   logic [15:0] ee_data, maker_ident_reg, product_ident, board_sub_vendor;
   logic [15:0] board_sub_ident, bus_param_word;
   logic [31:0] cfg_rd_data;
   logic [7:0] silicon_rev_reg;
   logic [4:0] diag_rev_mirror;
   logic [11:0] product_number;
   logic [3:0] product_variant, min_gnt;
   logic [5:0] max_lat;
   logic [47:0] node_addr_reg;
   int fails = 0;
   int total_checks = 0;
   int fetch_count = 0;
   eicl_loader #(.MAKER_IDENT(16'h3c3c), .ASIC_TYPE(3'h5), .REV_CODE(3'h6)) i_eicl_loader (
      .clk(clk),
      .rst_b(rst_b),
      .ee_req(ee_req),
      .ee_addr(ee_addr),
      .ee_ack(ee_ack),
      .ee_data(ee_data),
      .ee_large(ee_large),
      .ee_csum_addr(ee_csum_addr),
      .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr),
      .cfg_rd_valid(cfg_rd_valid),
      .cfg_retry(cfg_retry),
      .cfg_rd_data(cfg_rd_data),
      .silicon_rev_reg(silicon_rev_reg),
      .diag_rev_mirror(diag_rev_mirror),
      .maker_ident_reg(maker_ident_reg),
      .product_ident(product_ident),
      .product_number(product_number),
      .product_variant(product_variant),
      .board_sub_vendor(board_sub_vendor),
      .board_sub_ident(board_sub_ident),
      .node_addr_reg(node_addr_reg),
      .bus_param_word(bus_param_word),
      .pulsed_pme(pulsed_pme),
      .map_lower_meg(map_lower_meg),
      .no_mem_base(no_mem_base),
      .min_gnt(min_gnt),
      .max_lat(max_lat),
      .loaded(loaded)
   );
   eicl_ee_model i_eicl_ee_model (
      .clk(clk),
      .rst_b(rst_b),
      .ee_req(ee_req),
      .ee_addr(ee_addr),
      .dly(dly),
      .ee_ack(ee_ack),
      .ee_data(ee_data)
   );
   // completed fetches since the last reset
   always @(posedge clk) begin
      if (!rst_b) begin
         fetch_count <= 0;
      end else if (ee_req && ee_ack) begin
         fetch_count <= fetch_count + 1;
      end
   end
   function automatic logic [15:0] ew(input logic [9:0] a);
      return {a, 6'h25};
   endfunction
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test;
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_load(input logic [3:0] d);
      logic [15:0] bp;
      int i;
      bp = ew(EICL_EE_BUS_PARAM);
      @(posedge clk);
      dly <= d;
      rst_b <= 1'b0;
      cfg_rd <= 1'b1;
      cfg_addr <= EICL_CFG_IDENT;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1 chk("bus_param_word", bus_param_word, EICL_BUS_PARAM_RST);
      chk("cfg_retry", cfg_retry, 1'b1);
      chk("cfg_rd_valid", cfg_rd_valid, 1'b0);
      // look one step after each edge so the loaded flag has settled
      for (i = 0; i < 400 && loaded !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("loaded", loaded, 1'b1);
      if (loaded !== 1'b1) begin
         end_of_test();
      end
      chk("product_ident", product_ident, ew(EICL_EE_PRODUCT));
      chk("product_split", {product_number, product_variant}, ew(EICL_EE_PRODUCT));
      chk("board_sub_ident", board_sub_ident, ew(EICL_EE_SUB_IDENT));
      chk("board_sub_vendor", board_sub_vendor, ew(EICL_EE_SUB_VENDOR));
      chk("node_addr_reg", node_addr_reg, {ew(10'h00c), ew(10'h00b), ew(10'h00a)});
      chk("fetch_count", fetch_count, EICL_NFETCH);
      chk("bus_param_word", bus_param_word, bp);
      chk("bus_fields", {max_lat, min_gnt, no_mem_base, map_lower_meg, pulsed_pme},
         {bp[15:10], bp[9:6], bp[2], bp[1], bp[0]});
      @(posedge clk);
      cfg_rd <= 1'b0;
   endtask
   task automatic t_cfg;
      logic [7:0] a[6];
      logic [31:0] e[6];
      int i;
      a = '{8'h00, 8'h08, 8'h2c, 8'h04, 8'hfc, 8'h00};
      e = '{{ew(EICL_EE_PRODUCT), 16'h3c3c}, {24'h0, REV},
         {ew(EICL_EE_SUB_IDENT), ew(EICL_EE_SUB_VENDOR)}, 32'h0, 32'h0, 32'h0};
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         cfg_rd <= (i < 5);
         cfg_addr <= a[i];
         if (i > 0) begin
            #1 chk("cfg_rd_valid", cfg_rd_valid, 1'b1);
            chk("cfg_rd_data", cfg_rd_data, e[i-1]);
         end
      end
      @(posedge clk);
      #1 chk("cfg_rd_valid", cfg_rd_valid, 1'b0);
   endtask
   task automatic t_const;
      chk("silicon_rev_reg", silicon_rev_reg, REV);
      chk("diag_rev_mirror", diag_rev_mirror, REV[6:2]);
      chk("maker_ident_reg", maker_ident_reg, 16'h3c3c);
      @(posedge clk);
      ee_large <= 1'b1;
      #1 chk("ee_csum_addr", ee_csum_addr, 10'h3ff);
      @(posedge clk);
      ee_large <= 1'b0;
      #1 chk("ee_csum_addr", ee_csum_addr, 10'h0ff);
   endtask
   initial begin
      forever #2 clk = ~clk;
   end
   initial begin
      t_load(4'h0);
      t_cfg();
      t_const();
      t_load(4'h5);
      t_cfg();
      end_of_test();
   end
endmodule
